//--- verilog/dpll_reference_selector.sv
// Reference input selection and switchover control for one loop
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module dpll_reference_selector #(
  parameter int TW = 16                       // Timer and threshold width
) (
  input  wire logic        pclk,              // Loop clock, 10 MHz
  input  wire logic        presetn,           // Async reset, active low
  // APB slave
  input  wire logic        psel,              // Select
  input  wire logic        penable,           // Access phase
  input  wire logic        pwrite,            // Write when high
  input  wire logic [7:0]  paddr,             // Byte address
  input  wire logic [31:0] pwdata,            // Write data
  output logic [31:0]      prdata,            // Read data
  output logic             pready,            // Transfer done
  output logic             pslverr,           // Unmapped address
  // Monitor and loop inputs
  input  wire logic [1:0]  monitor_flags,     // Enabled monitor flags per input
  input  wire logic        history_valid,     // Tuning-word history usable
  input  wire logic        loop_locked,       // Loop lock status
  input  wire logic        inputs_freq_locked,// Inputs frequency-locked
  input  wire logic        manual_pin,        // Manual choice from pin
  // Outputs
  output logic             selected_input,    // Selected input status pin
  output logic             tracking,          // Loop tracks an input
  output logic             holdover,          // Loop in holdover
  output logic             free_run,          // Loop in free-run
  output logic [2:0]       switch_action,     // Hitless handling in force
  output logic             slew_active,       // Slew limiting running
  output logic [TW-1:0]    slew_limit,        // Phase step limit in force
  output logic [1:0]       freq_det_enable,   // Frequency detector enables
  output logic [1:0]       phase_valid_enable,// Phase-valid detector enables
  output logic             loop_soft_reset    // One-cycle loop soft reset
);
  initial begin
    if (TW < 8 || TW > 16) $error("dpll_reference_selector: TW out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [11:0]          ctrl;               // Control register
    logic [2:0]           prio0;              // Priority, first input
    logic [2:0]           prio1;              // Priority, second input
    logic [TW-1:0]        vtimer;             // Validation interval
    logic [TW-1:0]        thresh;             // Slew threshold
    logic [TW-1:0]        stimer;             // Slew timer
    logic                 sel;                // Selected input
    refsel_pkg::loop_state_e loop;            // Loop state
    refsel_pkg::sw_action_e  act;             // Last switch action
    logic [TW-1:0]        slew_cnt;           // Slew cycles left
    logic                 ever_locked;        // Loop has locked once
    logic                 pps_early_sw;       // 1-PPS switch before lock
    logic                 sreset;             // Soft reset pulse
    logic                 rdy;                // APB answer ready
    logic                 err;                // APB error
    logic [31:0]          rdata;              // APB read data
  } st_s;

  st_s st_q;
  st_s st_d;

  ////////////////////////////////////////////////////////////////////////
  // Input qualification
  logic [1:0] in_valid;                       // Qualified inputs

  input_validator #(.TW(TW)) u_val0 (
    .pclk    (pclk),
    .presetn (presetn),
    .flags   (monitor_flags[0]),
    .timer   (st_q.vtimer),
    .valid   (in_valid[0])
  );

  input_validator #(.TW(TW)) u_val1 (
    .pclk    (pclk),
    .presetn (presetn),
    .flags   (monitor_flags[1]),
    .timer   (st_q.vtimer),
    .valid   (in_valid[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  refsel_pkg::sel_mode_e mode;                // Selection mode
  logic                  man_sel;             // Manual choice in force
  logic                  cancel_en;           // Phase cancellation
  logic                  slew_en;             // Phase slew control
  logic                  zds_en;              // Zero-delay sync
  logic                  pps_en;              // Inputs are 1-PPS
  logic [1:0]            fdet_cfg;            // Frequency detector request
  logic [1:0]            pvdet_cfg;           // Phase-valid request
  logic [1:0]            det_conflict;        // Both requested per input

  always_comb begin
    mode      = refsel_pkg::sel_mode_e'(st_q.ctrl[refsel_pkg::CTRL_MODE_LSB +: 2]);
    cancel_en = st_q.ctrl[refsel_pkg::CTRL_CANCEL];
    slew_en   = st_q.ctrl[refsel_pkg::CTRL_SLEW];
    zds_en    = st_q.ctrl[refsel_pkg::CTRL_ZDS];
    pps_en    = st_q.ctrl[refsel_pkg::CTRL_PPS];
    fdet_cfg  = st_q.ctrl[refsel_pkg::CTRL_FDET_LSB +: 2];
    pvdet_cfg = st_q.ctrl[refsel_pkg::CTRL_PVDET_LSB +: 2];
    // Register field or pin, as configured
    if (st_q.ctrl[refsel_pkg::CTRL_PINSRC]) begin
      man_sel = manual_pin;
    end else begin
      man_sel = st_q.ctrl[refsel_pkg::CTRL_MANSEL];
    end
  end

  // The frequency detector wins on a conflict; the phase-valid detector
  // is held off so the two never run on one input
  assign det_conflict       = fdet_cfg & pvdet_cfg;
  assign freq_det_enable    = fdet_cfg;
  assign phase_valid_enable = pvdet_cfg & ~fdet_cfg;

  ////////////////////////////////////////////////////////////////////////
  // Priority ranking
  logic [1:0] eligible;                       // Valid with nonzero priority
  logic       any_elig;                       // Some input eligible
  logic       best;                           // Best eligible input

  always_comb begin
    eligible[0] = in_valid[0] && (st_q.prio0 != 3'h0);
    eligible[1] = in_valid[1] && (st_q.prio1 != 3'h0);
    any_elig    = |eligible;
    best        = 1'b0;
    if (eligible[1] && !eligible[0]) begin
      best = 1'b1;
    end else if (eligible[1] && (st_q.prio1 < st_q.prio0)) begin
      best = 1'b1;
    end else begin
      best = 1'b0;                            // Ties go to first input
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Selection decision
  logic                    nxt_sel;           // Next selection
  logic                    nxt_trk;           // Next cycle tracks
  refsel_pkg::loop_state_e lost_state;        // State when nothing usable

  always_comb begin
    // Holdover needs a usable tuning-word history
    if (history_valid) begin
      lost_state = refsel_pkg::LOOP_HOLDOVER;
    end else begin
      lost_state = refsel_pkg::LOOP_FREERUN;
    end
    nxt_sel = st_q.sel;
    nxt_trk = 1'b0;
    case (mode)
      refsel_pkg::MODE_AUTO_REV: begin
        // Always the best input, switching as soon as it qualifies
        if (any_elig) begin
          nxt_sel = best;
          nxt_trk = 1'b1;
        end
      end
      refsel_pkg::MODE_AUTO_NONREV: begin
        // Stay with a still-eligible current input
        if (st_q.loop == refsel_pkg::LOOP_TRACK && eligible[st_q.sel]) begin
          nxt_trk = 1'b1;
        end else if (any_elig) begin
          nxt_sel = best;
          nxt_trk = 1'b1;
        end
      end
      refsel_pkg::MODE_MAN_FALLBK: begin
        // Manual input first, best valid input otherwise
        if (in_valid[man_sel]) begin
          nxt_sel = man_sel;
          nxt_trk = 1'b1;
        end else if (any_elig) begin
          nxt_sel = best;
          nxt_trk = 1'b1;
        end
      end
      refsel_pkg::MODE_MAN_HOLDOV: begin
        // Never falls back to the other input
        nxt_sel = man_sel;
        nxt_trk = in_valid[man_sel];
      end
      default: begin
        nxt_trk = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Switch event classification
  logic                   sw_inputs;          // Input-to-input switchover
  logic                   sw_exit;            // Holdover/free-run exit
  logic                   pps_no_hitless;     // Hitless barred for 1-PPS
  refsel_pkg::sw_action_e sw_act;             // Action for this event

  always_comb begin
    sw_inputs      = (st_q.loop == refsel_pkg::LOOP_TRACK) && nxt_trk &&
                     (nxt_sel != st_q.sel);
    sw_exit        = (st_q.loop != refsel_pkg::LOOP_TRACK) && nxt_trk;
    // Zero-delay sync, or no lock yet, rules out hitless 1-PPS switching
    pps_no_hitless = pps_en && (zds_en || !st_q.ever_locked);
    sw_act         = refsel_pkg::ACT_NONE;
    if (sw_exit) begin
      if (slew_en) begin
        sw_act = refsel_pkg::ACT_SLEW;
      end else begin
        sw_act = refsel_pkg::ACT_FAST;
      end
    end else if (sw_inputs) begin
      if (pps_no_hitless || (!cancel_en && !slew_en)) begin
        sw_act = refsel_pkg::ACT_FULL;
      end else if (cancel_en && inputs_freq_locked) begin
        sw_act = refsel_pkg::ACT_CANCEL;
      end else if (slew_en) begin
        sw_act = refsel_pkg::ACT_SLEW;
      end else begin
        sw_act = refsel_pkg::ACT_SMOOTH;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register access decode
  logic        acc;                           // Access phase with answer
  logic        wr;                            // Write takes effect
  logic        mapped;                        // Address hits a register
  logic [31:0] rd_val;                        // Read value for address
  logic [31:0] status;                        // Status word

  always_comb begin
    acc    = psel && penable && st_q.rdy;
    wr     = acc && pwrite && !st_q.err;
    status = 32'h0000_0000;
    status[0]   = st_q.sel;
    status[2:1] = st_q.loop;
    status[4:3] = in_valid;
    status[5]   = loop_locked;
    status[6]   = st_q.ever_locked;
    status[7]   = st_q.pps_early_sw;
    status[9:8] = det_conflict;
    status[10]  = slew_active;
    status[13:11] = st_q.act;
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      refsel_pkg::OFF_CTRL: begin
        rd_val[11:0] = st_q.ctrl;
      end
      refsel_pkg::OFF_PRIO: begin
        rd_val[refsel_pkg::PRIO0_LSB +: refsel_pkg::PRIO_W] = st_q.prio0;
        rd_val[refsel_pkg::PRIO1_LSB +: refsel_pkg::PRIO_W] = st_q.prio1;
      end
      refsel_pkg::OFF_VTIMER: begin
        rd_val[TW-1:0] = st_q.vtimer;
      end
      refsel_pkg::OFF_SLEW: begin
        rd_val[TW-1:0]     = st_q.thresh;
        rd_val[16 +: TW]   = st_q.stimer;
      end
      refsel_pkg::OFF_STATUS: begin
        rd_val = status;
      end
      refsel_pkg::OFF_CMD: begin
        rd_val = 32'h0000_0000;               // Command reads as zero
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.sreset = 1'b0;
    // One wait-free access phase; read data captured in the setup cycle
    st_d.rdy    = psel && !penable;
    st_d.err    = psel && !penable && !mapped;
    st_d.rdata  = (psel && !penable && !pwrite && mapped) ? rd_val : 32'h0000_0000;
    // Register writes
    if (wr) begin
      case (paddr)
        refsel_pkg::OFF_CTRL: begin
          st_d.ctrl = pwdata[11:0];
        end
        refsel_pkg::OFF_PRIO: begin
          st_d.prio0 = pwdata[refsel_pkg::PRIO0_LSB +: refsel_pkg::PRIO_W];
          st_d.prio1 = pwdata[refsel_pkg::PRIO1_LSB +: refsel_pkg::PRIO_W];
        end
        refsel_pkg::OFF_VTIMER: begin
          st_d.vtimer = pwdata[TW-1:0];
        end
        refsel_pkg::OFF_SLEW: begin
          st_d.thresh = pwdata[TW-1:0];
          st_d.stimer = pwdata[16 +: TW];
        end
        refsel_pkg::OFF_CMD: begin
          // Soft reset restarts lock tracking after an early switch
          if (pwdata[refsel_pkg::CMD_SOFT_RESET]) begin
            st_d.sreset = 1'b1;
          end
        end
        default: begin
          st_d.sreset = 1'b0;
        end
      endcase
    end
    // Loop state and selection
    st_d.sel = nxt_sel;
    if (nxt_trk) begin
      st_d.loop = refsel_pkg::LOOP_TRACK;
    end else begin
      st_d.loop = lost_state;
    end
    // Record the action and arm slew limiting
    if (sw_act != refsel_pkg::ACT_NONE) begin
      st_d.act = sw_act;
    end
    if (sw_act == refsel_pkg::ACT_SLEW) begin
      st_d.slew_cnt = st_q.stimer;
    end else if (st_q.slew_cnt != '0) begin
      st_d.slew_cnt = st_q.slew_cnt - 1'b1;
    end
    // First lock and early 1-PPS switch tracking; the event wins over
    // the clearing soft reset in the same cycle
    if (st_q.sreset) begin
      st_d.ever_locked  = 1'b0;
      st_d.pps_early_sw = 1'b0;
    end
    if (loop_locked) begin
      st_d.ever_locked = 1'b1;
    end
    if (sw_inputs && pps_en && !st_q.ever_locked) begin
      st_d.pps_early_sw = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.ctrl         <= refsel_pkg::CTRL_RST;
      st_q.prio0        <= refsel_pkg::PRIO0_RST;
      st_q.prio1        <= refsel_pkg::PRIO1_RST;
      st_q.vtimer       <= refsel_pkg::VTIMER_RST[TW-1:0];
      st_q.thresh       <= refsel_pkg::THRESH_RST[TW-1:0];
      st_q.stimer       <= refsel_pkg::STIMER_RST[TW-1:0];
      st_q.sel          <= 1'b0;
      st_q.loop         <= refsel_pkg::LOOP_FREERUN;
      st_q.act          <= refsel_pkg::ACT_NONE;
      st_q.slew_cnt     <= '0;
      st_q.ever_locked  <= 1'b0;
      st_q.pps_early_sw <= 1'b0;
      st_q.sreset       <= 1'b0;
      st_q.rdy          <= 1'b0;
      st_q.err          <= 1'b0;
      st_q.rdata        <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata          = st_q.rdata;
  assign pready          = st_q.rdy;
  assign pslverr         = st_q.err;
  assign selected_input  = st_q.sel;
  assign tracking        = (st_q.loop == refsel_pkg::LOOP_TRACK);
  assign holdover        = (st_q.loop == refsel_pkg::LOOP_HOLDOVER);
  assign free_run        = (st_q.loop == refsel_pkg::LOOP_FREERUN);
  assign switch_action   = st_q.act;
  assign slew_active     = (st_q.slew_cnt != '0);
  // The limit only applies while the slew timer runs
  assign slew_limit      = slew_active ? st_q.thresh : '0;
  assign loop_soft_reset = st_q.sreset;
endmodule : dpll_reference_selector

//--- verilog/refsel_pkg.sv
// Constants, types and register map of the reference input selector
package refsel_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PRIO   = 8'h04;
  localparam logic [7:0] OFF_VTIMER = 8'h08;
  localparam logic [7:0] OFF_SLEW   = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CMD    = 8'h14;
  // Control field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MANSEL     = 2;
  localparam int CTRL_PINSRC     = 3;
  localparam int CTRL_CANCEL     = 4;
  localparam int CTRL_SLEW       = 5;
  localparam int CTRL_ZDS        = 6;
  localparam int CTRL_PPS        = 7;
  localparam int CTRL_FDET_LSB   = 8;
  localparam int CTRL_PVDET_LSB  = 10;
  localparam int CTRL_WIDTH      = 12;
  // Priority field positions
  localparam int PRIO0_LSB       = 0;
  localparam int PRIO1_LSB       = 4;
  localparam int PRIO_W          = 3;
  // Command bit
  localparam int CMD_SOFT_RESET  = 0;
  // Values after reset
  localparam logic [11:0] CTRL_RST   = 12'h000;
  localparam logic [2:0]  PRIO0_RST  = 3'h1;
  localparam logic [2:0]  PRIO1_RST  = 3'h2;
  localparam logic [15:0] VTIMER_RST = 16'h0010;
  localparam logic [15:0] THRESH_RST = 16'h0100;
  localparam logic [15:0] STIMER_RST = 16'h0040;
  // Selection modes
  typedef enum logic [1:0] {
    MODE_AUTO_REV    = 2'b00,
    MODE_AUTO_NONREV = 2'b01,
    MODE_MAN_FALLBK  = 2'b10,
    MODE_MAN_HOLDOV  = 2'b11
  } sel_mode_e;
  // Loop states
  typedef enum logic [1:0] {
    LOOP_FREERUN  = 2'b00,
    LOOP_HOLDOVER = 2'b01,
    LOOP_TRACK    = 2'b10
  } loop_state_e;
  // Action taken on a switch event
  typedef enum logic [2:0] {
    ACT_NONE   = 3'b000,
    ACT_CANCEL = 3'b001,
    ACT_SMOOTH = 3'b010,
    ACT_SLEW   = 3'b011,
    ACT_FULL   = 3'b100,
    ACT_FAST   = 3'b101
  } sw_action_e;
endpackage : refsel_pkg

//--- verilog/input_validator.sv
// Validation timer that qualifies one reference input
`timescale 1ns/1ps
module input_validator #(
  parameter int TW = 16                  // Timer width
) (
  input  wire logic          pclk,       // Loop clock
  input  wire logic          presetn,    // Async reset, active low
  input  wire logic          flags,      // OR of enabled monitor flags
  input  wire logic [TW-1:0] timer,      // Clear interval in cycles
  output logic               valid       // Input qualified
);
  initial begin
    if (TW < 2) $error("input_validator: TW too small");
  end

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [TW-1:0] cnt;                  // Cycles free of flags
    logic          ok;                   // Qualified
  } val_s;

  val_s st_q;
  val_s st_d;

  // Any flag restarts the clear interval; a gap that the monitors were
  // set up to tolerate never raises a flag, so gapped clocks qualify
  always_comb begin
    st_d = st_q;
    if (flags) begin
      st_d.cnt = '0;
      st_d.ok  = 1'b0;
    end else if (st_q.cnt >= timer) begin
      st_d.ok  = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign valid = st_q.ok;
endmodule : input_validator

//--- verification/refsel_checker.sv
// Port assertions of the reference selector
`timescale 1ns/1ps
module refsel_checker #(
  parameter int TW = 16
) (
  input wire logic          pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [31:0]   prdata,
  input wire logic [1:0]    monitor_flags, freq_det_enable, phase_valid_enable,
  input wire logic          history_valid, tracking, holdover, free_run,
  input wire logic          slew_active, loop_soft_reset,
  input wire logic [TW-1:0] slew_limit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states: the access cycle always answers
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  // A refused access carries no data
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without clean answer");
  // Exactly one loop state at a time
  a_state_onehot: assert property ($onehot({tracking, holdover, free_run}))
    else $error("loop state not one-hot");
  // Both inputs flagged long enough: no tracking left
  a_lost_inputs: assert property ((monitor_flags == 2'b11) [*4] |-> !tracking)
    else $error("tracking with no valid input");
  // Holdover only entered with usable history
  a_holdover_hist: assert property ($rose(holdover) |-> $past(history_valid))
    else $error("holdover without history");
  // The step limit only applies while slewing
  a_slew_limit: assert property (!slew_active |-> slew_limit == '0)
    else $error("slew limit outside slewing");
  // Soft reset is a single-cycle pulse
  a_reset_pulse: assert property (loop_soft_reset |=> !loop_soft_reset)
    else $error("soft reset longer than one cycle");
  // Detectors never share an input
  a_det_exclusive: assert property ((freq_det_enable & phase_valid_enable) == 2'h0)
    else $error("both detectors enabled");
endmodule : refsel_checker
bind dpll_reference_selector refsel_checker #(.TW(TW)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .monitor_flags(monitor_flags),
  .freq_det_enable(freq_det_enable), .phase_valid_enable(phase_valid_enable),
  .history_valid(history_valid), .tracking(tracking), .holdover(holdover),
  .free_run(free_run), .slew_active(slew_active), .loop_soft_reset(loop_soft_reset),
  .slew_limit(slew_limit));

//--- verification/ref_source_model.sv
// Model of the two reference sources and their monitors
`timescale 1ns/1ps
module ref_source_model (
  input  wire logic       pclk,
  input  wire logic [1:0] fail,               // Source disturbed, per input
  input  wire logic       common_master,      // Both sources share one master
  output logic      [1:0] monitor_flags,      // Monitor flags seen by the loop
  output logic            inputs_freq_locked  // Inputs frequency-locked
);
  // Gaps stay within one period, so only a real fault raises a flag
  initial monitor_flags = 2'b11;
  always @(posedge pclk) begin
    monitor_flags <= fail;
  end
  // Separate masters let the sources drift, so unlocked switches can be run
  assign inputs_freq_locked = common_master;
endmodule : ref_source_model

//--- verification/tb_dpll_reference_selector.sv
// Testbench of the reference selector
`timescale 1ns/1ps
module tb_dpll_reference_selector;
  logic        pclk, presetn, psel, penable, pwrite, history_valid, loop_locked;
  logic        manual_pin, pready, pslverr, err, selected_input, tracking, holdover;
  logic        free_run, slew_active, inputs_freq_locked, loop_soft_reset, common_master;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  monitor_flags, fail, freq_det_enable, phase_valid_enable;
  logic [2:0]  switch_action;
  logic [15:0] slew_limit;
  int          errors, n_checks, pulses;
  // Expected {loop state, selected input}
  localparam logic [2:0] T0 = {refsel_pkg::LOOP_TRACK, 1'b0};
  localparam logic [2:0] T1 = {refsel_pkg::LOOP_TRACK, 1'b1};
  localparam logic [2:0] HO = {refsel_pkg::LOOP_HOLDOVER, 1'b0};
  localparam logic [2:0] FR = {refsel_pkg::LOOP_FREERUN, 1'b0};
  dpll_reference_selector #(.TW(16)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_flags(monitor_flags), .history_valid(history_valid), .loop_locked(loop_locked),
    .inputs_freq_locked(inputs_freq_locked), .manual_pin(manual_pin),
    .selected_input(selected_input), .tracking(tracking), .holdover(holdover),
    .free_run(free_run), .switch_action(switch_action), .slew_active(slew_active),
    .slew_limit(slew_limit), .freq_det_enable(freq_det_enable),
    .phase_valid_enable(phase_valid_enable), .loop_soft_reset(loop_soft_reset));
  ref_source_model src_u (
    .pclk(pclk), .fail(fail), .common_master(common_master), .monitor_flags(monitor_flags),
    .inputs_freq_locked(inputs_freq_locked));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Count soft reset pulses
  always @(posedge pclk) begin
    if (loop_soft_reset === 1'b1) pulses++;
  end
  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    if (i == 20) begin
      errors++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let qualification settle, then read loop state and selection
  task automatic st(input logic [2:0] e, input logic [2:0] m);
    repeat (20) @(posedge pclk);
    apb(1'b0, refsel_pkg::OFF_STATUS, 32'h0);
    chk({29'h0, rd[2:0] & m}, {29'h0, e});
  endtask : st
  initial begin
    {psel, penable, pwrite, presetn, history_valid, loop_locked, manual_pin} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail = 2'b11;
    common_master = 1'b1;
    errors = 0;
    n_checks = 0;
    pulses = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, refsel_pkg::OFF_PRIO, 32'h0);
    chk(rd, {25'h0, refsel_pkg::PRIO1_RST, 1'b0, refsel_pkg::PRIO0_RST});
    apb(1'b0, refsel_pkg::OFF_SLEW, 32'h0);
    chk(rd, {refsel_pkg::STIMER_RST, refsel_pkg::THRESH_RST});
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, refsel_pkg::OFF_VTIMER, 32'h4);
    st(FR, 3'h6);
    fail <= 2'b00;
    st(T0, 3'h7);
    chk({31'h0, selected_input}, 32'h0);
    fail <= 2'b01;
    st(T1, 3'h7);
    fail <= 2'b00;
    st(T0, 3'h7);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h1);
    fail <= 2'b01;
    st(T1, 3'h7);
    fail <= 2'b00;
    st(T1, 3'h7);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, refsel_pkg::OFF_PRIO, 32'h33);
    st(T0, 3'h7);
    apb(1'b1, refsel_pkg::OFF_PRIO, 32'h30);
    st(T1, 3'h7);
    apb(1'b1, refsel_pkg::OFF_PRIO, 32'h21);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h7);
    history_valid <= 1'b1;
    st(T1, 3'h7);
    fail <= 2'b10;
    st(HO, 3'h6);
    fail <= 2'b00;
    st(T1, 3'h7);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'hA);
    manual_pin <= 1'b1;
    st(T1, 3'h7);
    fail <= 2'b10;
    st(T0, 3'h7);
    history_valid <= 1'b0;
    fail <= 2'b11;
    st(FR, 3'h6);
    apb(1'b1, refsel_pkg::OFF_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    chk(pulses, 32'h1);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'hF00);
    @(posedge pclk);
    chk({28'h0, freq_det_enable, phase_valid_enable}, 32'hC);
    apb(1'b0, refsel_pkg::OFF_STATUS, 32'h0);
    chk({30'h0, rd[9:8]}, 32'h3);
    // Hitless handling picked for each kind of switch event
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h0);
    fail <= 2'b00;
    st(T0, 3'h7);
    chk({29'h0, switch_action}, 32'h5);
    fail <= 2'b01;
    st(T1, 3'h7);
    chk({29'h0, switch_action}, 32'h4);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h90);
    loop_locked <= 1'b1;
    fail <= 2'b00;
    st(T0, 3'h7);
    chk({29'h0, switch_action}, 32'h1);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'hD0);
    fail <= 2'b01;
    st(T1, 3'h7);
    chk({29'h0, switch_action}, 32'h4);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h10);
    common_master <= 1'b0;
    fail <= 2'b00;
    st(T0, 3'h7);
    chk({29'h0, switch_action}, 32'h2);
    apb(1'b1, refsel_pkg::OFF_CTRL, 32'h20);
    fail <= 2'b11;
    st(FR, 3'h6);
    fail <= 2'b00;
    st(T0, 3'h7);
    chk({29'h0, switch_action}, 32'h3);
    chk({31'h0, slew_active}, 32'h1);
    chk({16'h0, slew_limit}, {16'h0, refsel_pkg::THRESH_RST});
    close_out();
  end
endmodule : tb_dpll_reference_selector
